// >>> core/dcm_msg_handler.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: 81H plus data writes config zero; 82H reads
// R2: 83H plus data loads reference; 84H reads
// R3: Reference code starts at 40H after reset
// R4: 85H and 86H request status, no data
// R5: 87H plus data writes config two; 88H reads
// R6: Config zero bit 6 keeps pull-up while disabled
// R7: Bit 5 selects sleep, forcing pull-up disconnect
// R8: Bit 4 enables neutral simulator, default off
// R9: Bit 3 set disables gate lockout
// R10: Bit 2 set disables short-circuit detection
// R11: Bits 1:0 pick overcurrent threshold
// R12: Config two bits 4:2 select dead time
// R13: Config two bits 1:0 select blanking time
// R14: Reply header echoes command, bit 6 acks
// R15: Reference acks carry the code in effect
// R16: Status acks 45H/46H then status byte
// R17: Unsolicited status headers are 85H and 86H
// R18: Status zero carries supply and thermal flags
// R19: Status one carries gate, overcurrent, 5V flags
// R20: Configuration-lost flag is set after reset
// R21: Config two replies 07H/47H and 08H/48H
// R22: Bytes are 9600 baud, start, eight, stop
// R23: Missing data byte draws rejection after 5 ms
// R24: Unsolicited message only on flag rising
// R25: Lost flag clears on sending 46H ack
// R26: Reserved configuration bits always read zero
// R27: Unknown command is rejected with echo
module dcm_msg_handler #(
   parameter int BIT_CYCLES = dcm_pkg::BIT_CYCLES,
   parameter int TIMEOUT_CYCLES = dcm_pkg::DATA_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // Single-wire host link, open drain
   input wire logic I_LINK_IN,
   output logic O_LINK_OUT,
   output logic O_LINK_OE_N,
   // Device state
   input wire logic I_CHIP_EN,
   input wire logic [7:0] I_SUPPLY_FLAGS,
   input wire logic [7:0] I_GATE_FLAGS,
   // Configuration to the analog blocks
   output dcm_pkg::dcm_cfg_t O_CFG,
   output logic O_CFG_LOST
);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_DATA,
      ST_TX_HDR,
      ST_TX_DATA
   } dcm_state_t;

   dcm_state_t state;
   logic [7:0] cfg0;
   logic [7:0] cfg_ref;
   logic [7:0] cfg2;
   logic cfg_lost;
   logic [7:0] stat0;
   logic [7:0] stat1;
   logic [7:0] prev0;
   logic [7:0] prev1;
   logic pend0;
   logic pend1;
   logic [7:0] cmd;
   logic [7:0] resp_hdr;
   logic [7:0] resp_data;
   logic resp_two;
   logic [TW-1:0] timer;
   logic rx_valid;
   logic [7:0] rx_data;
   logic rx_busy;
   logic tx_valid;
   logic [7:0] tx_data;
   logic tx_ready;
   logic drive_low;
   logic wr_en;
   logic timeout;
   logic can_send;
   logic launch0;
   logic launch1;
   logic cmd_rx;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [7:0] reply_hdr(input logic [7:0] c, input logic ack);
      logic [7:0] h;
      h = c;
      h[dcm_pkg::CMD_FLAG_BIT] = 1'b0;
      h[dcm_pkg::ACK_FLAG_BIT] = ack;
      return h;
   endfunction : reply_hdr

   function automatic logic [7:0] write_value(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (c == dcm_pkg::CMD_SET_CFG0) begin
         v = d & dcm_pkg::CFG0_WRITE_MASK;
      end else if (c == dcm_pkg::CMD_SET_CFG2) begin
         v = d & dcm_pkg::CFG2_WRITE_MASK;
      end
      return v;
   endfunction : write_value

   // ************************************************************
   // Link framer
   // ************************************************************
   dcm_link_uart #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_uart (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_line(I_LINK_IN),
      .o_drive_low(drive_low),
      .o_rx_valid(rx_valid),
      .o_rx_data(rx_data),
      .o_rx_busy(rx_busy),
      .i_tx_valid(tx_valid),
      .i_tx_data(tx_data),
      .o_tx_ready(tx_ready)
   );

   // Only ever pulls low; the pull-up gives the high level
   assign O_LINK_OUT = 1'b0;
   assign O_LINK_OE_N = !drive_low;
   assign O_CFG_LOST = cfg_lost;

   // ************************************************************
   // Status bytes and event detection
   // ************************************************************
   assign stat0 = I_SUPPLY_FLAGS; // [R18]
   assign stat1 = (I_GATE_FLAGS & dcm_pkg::STAT1_LIVE_MASK) | (cfg_lost ? dcm_pkg::STAT1_CFG_LOST : 8'h00); // [R19]

   assign cmd_rx = (state == ST_IDLE) && rx_valid && rx_data[dcm_pkg::CMD_FLAG_BIT];
   assign wr_en = (state == ST_WAIT_DATA) && rx_valid;
   assign timeout = (state == ST_WAIT_DATA) && !rx_valid && (timer == TW'(TIMEOUT_CYCLES - 1));
   // Never start talking over a host byte in progress
   assign can_send = (state == ST_IDLE) && !rx_valid && !rx_busy && tx_ready && I_CHIP_EN;
   assign launch0 = can_send && pend0;
   assign launch1 = can_send && !pend0 && pend1;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         prev0 <= 8'h00;
         prev1 <= 8'h00;
         pend0 <= 1'b0;
         pend1 <= 1'b1; // [R20]
      end else begin
         prev0 <= stat0;
         prev1 <= stat1 & dcm_pkg::STAT1_LIVE_MASK;
         // A new rising flag wins over the clear of the same cycle
         pend0 <= (pend0 && !launch0) || (|(stat0 & ~prev0)); // [R24]
         pend1 <= (pend1 && !launch1) || (|(stat1 & dcm_pkg::STAT1_LIVE_MASK & ~prev1)); // [R24]
      end
   end

   // ************************************************************
   // Configuration-lost flag
   // ************************************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         cfg_lost <= 1'b1; // [R20]
      end else if (state == ST_TX_HDR && tx_ready && resp_hdr == dcm_pkg::ACK_STAT1) begin
         cfg_lost <= 1'b0; // [R25]
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         cfg0 <= dcm_pkg::CFG0_RESET;
         cfg_ref <= dcm_pkg::REF_RESET; // [R3]
         cfg2 <= dcm_pkg::CFG2_RESET;
      end else if (wr_en) begin
         unique case (cmd)
            dcm_pkg::CMD_SET_CFG0: cfg0 <= write_value(cmd, rx_data); // [R1] [R26]
            dcm_pkg::CMD_SET_REF: cfg_ref <= rx_data; // [R2]
            dcm_pkg::CMD_SET_CFG2: cfg2 <= write_value(cmd, rx_data); // [R5] [R26]
            default: cfg0 <= cfg0;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         O_CFG <= dcm_pkg::CFG_OUT_RESET;
      end else begin
         // Sleep always drops the pull-up while disabled
         O_CFG.pullup_connect <= I_CHIP_EN ||
            (cfg0[dcm_pkg::CFG0_PULLUP_BIT] && !cfg0[dcm_pkg::CFG0_SLEEP_BIT]); // [R6] [R7]
         O_CFG.sleep_sel <= cfg0[dcm_pkg::CFG0_SLEEP_BIT]; // [R7]
         O_CFG.neutral_sim_en <= cfg0[dcm_pkg::CFG0_NEUTRAL_BIT]; // [R8]
         O_CFG.gate_lockout_en <= !cfg0[dcm_pkg::CFG0_GATE_LOCK_BIT]; // [R9]
         O_CFG.short_detect_en <= !cfg0[dcm_pkg::CFG0_SHORT_BIT]; // [R10]
         O_CFG.oc_thresh <= cfg0[dcm_pkg::CFG0_OC_LSB +: 2]; // [R11]
         O_CFG.current_ref <= cfg_ref; // [R2]
         O_CFG.dead_time_sel <= cfg2[dcm_pkg::CFG2_DEAD_LSB +: 3]; // [R12]
         O_CFG.blank_time_sel <= cfg2[dcm_pkg::CFG2_BLANK_LSB +: 2]; // [R13]
      end
   end

   // ************************************************************
   // Command decode and reply sequencing
   // ************************************************************
   assign tx_valid = (state == ST_TX_HDR) || (state == ST_TX_DATA);
   assign tx_data = (state == ST_TX_DATA) ? resp_data : resp_hdr;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         state <= ST_IDLE;
         cmd <= 8'h00;
         resp_hdr <= 8'h00;
         resp_data <= 8'h00;
         resp_two <= 1'b0;
         timer <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (cmd_rx) begin
                  cmd <= rx_data;
                  timer <= '0;
                  resp_two <= 1'b1;
                  resp_hdr <= reply_hdr(rx_data, 1'b1); // [R14]
                  state <= ST_TX_HDR;
                  unique case (rx_data)
                     dcm_pkg::CMD_SET_CFG0, dcm_pkg::CMD_SET_REF, dcm_pkg::CMD_SET_CFG2: begin
                        state <= ST_WAIT_DATA; // [R1] [R2] [R5]
                     end
                     dcm_pkg::CMD_GET_CFG0: resp_data <= cfg0; // [R1]
                     dcm_pkg::CMD_GET_REF: resp_data <= cfg_ref; // [R15]
                     dcm_pkg::CMD_STAT0: resp_data <= stat0; // [R4] [R16]
                     dcm_pkg::CMD_STAT1: resp_data <= stat1; // [R4] [R16]
                     dcm_pkg::CMD_GET_CFG2: resp_data <= cfg2; // [R21]
                     default: begin
                        resp_two <= 1'b0;
                        resp_hdr <= reply_hdr(rx_data, 1'b0); // [R27]
                     end
                  endcase
               end else if (launch0) begin
                  resp_hdr <= dcm_pkg::CMD_STAT0; // [R17]
                  resp_data <= stat0;
                  resp_two <= 1'b1;
                  state <= ST_TX_HDR;
               end else if (launch1) begin
                  resp_hdr <= dcm_pkg::CMD_STAT1; // [R17]
                  resp_data <= stat1;
                  resp_two <= 1'b1;
                  state <= ST_TX_HDR;
               end
            end
            ST_WAIT_DATA: begin
               timer <= timer + 1'b1;
               if (wr_en) begin
                  resp_hdr <= reply_hdr(cmd, 1'b1); // [R14] [R21]
                  resp_data <= write_value(cmd, rx_data); // [R15]
                  resp_two <= 1'b1;
                  state <= ST_TX_HDR;
               end else if (timeout) begin
                  resp_hdr <= reply_hdr(cmd, 1'b0); // [R23]
                  resp_two <= 1'b0;
                  state <= ST_TX_HDR;
               end
            end
            ST_TX_HDR: begin
               if (tx_ready) begin
                  state <= resp_two ? ST_TX_DATA : ST_IDLE;
               end
            end
            ST_TX_DATA: begin
               if (tx_ready) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_ref_reset_value: assert property (@(posedge I_CLK_SYS) $fell(I_RST) |-> cfg_ref == 8'h40 ##1 O_CFG.current_ref == 8'h40) // [R3]
      else $error("Reference code not 40H after reset");

   a_lost_after_reset: assert property (@(posedge I_CLK_SYS) $fell(I_RST) |-> cfg_lost && pend1) // [R20]
      else $error("Configuration-lost flag not set after reset");

   a_lost_clear_cause: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      $fell(cfg_lost) |-> $past(state == ST_TX_HDR && tx_ready && tx_data == 8'h46)) // [R25]
      else $error("Configuration-lost flag cleared without 46H ack");

   a_reserved_bits_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      cfg0[7] == 1'b0 && cfg2[7:5] == 3'h0) // [R26]
      else $error("Reserved configuration bits not zero");

   a_sleep_pullup_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      cfg0[5] && !I_CHIP_EN |=> !O_CFG.pullup_connect && O_CFG.sleep_sel) // [R7]
      else $error("Pull-up kept connected in sleep");

   a_timeout_reject: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state == ST_WAIT_DATA ##1 (state == ST_WAIT_DATA && !rx_valid)[*8] ##0 timer == TW'(TIMEOUT_CYCLES - 1)
      |=> state == ST_TX_HDR && resp_hdr == {2'b00, cmd[5:0]} && !resp_two) // [R23]
      else $error("Missing data byte not rejected on time");

   a_status_ack: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state == ST_IDLE && rx_valid && rx_data == 8'h85
      |=> state == ST_TX_HDR && resp_hdr == 8'h45 && resp_two ##0 tx_data == 8'h45) // [R16]
      else $error("Status zero request not acknowledged with 45H");

   a_unknown_reject: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state == ST_IDLE && rx_valid && rx_data[7] && (rx_data[6:5] != 2'b00 || rx_data[4:0] > 5'h08 || rx_data[4:0] == 5'h00)
      |=> resp_hdr == {2'b00, $past(rx_data[5:0])} && !resp_two) // [R27]
      else $error("Unknown command not rejected with echo");

   a_cfg2_write: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state == ST_WAIT_DATA && rx_valid && cmd == 8'h87
      |=> cfg2 == {3'b000, $past(rx_data[4:0])} && resp_hdr == 8'h47 ##1 O_CFG.dead_time_sel == cfg2[4:2]) // [R21]
      else $error("Config two write not applied or not acked with 47H");

   a_unsol_on_rise: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      launch0 |=> state == ST_TX_HDR && resp_hdr == 8'h85 && (!pend0 || $past(|(stat0 & ~prev0)))) // [R24]
      else $error("Unsolicited status zero message malformed");

   a_cfg0_write: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state == ST_WAIT_DATA && rx_valid && cmd == 8'h81
      |=> cfg0 == {1'b0, $past(rx_data[6:0])} && resp_hdr == 8'h41 && resp_data == cfg0) // [R1]
      else $error("Config zero write not applied or not acked with 41H");

   a_pend_set_wins: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (|(stat1 & 8'h2c & ~prev1)) |=> pend1) // [R24]
      else $error("Rising status one flag not marked pending");

   a_ref_read_reply: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state == ST_IDLE && rx_valid && rx_data == 8'h84
      |=> state == ST_TX_HDR && resp_hdr == 8'h44 && resp_data == cfg_ref && resp_two) // [R15]
      else $error("Reference read not acked with 44H and the code");

endmodule : dcm_msg_handler

// >>> core/dcm_pkg.sv
// ************************************************************
// Constants and types of the configuration message handler
// ************************************************************
package dcm_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int LINK_BAUD = 9600;
   // Nearest whole cycle; the residual error is far inside a UART's tolerance
   localparam int BIT_CYCLES = (CLK_HZ + LINK_BAUD / 2) / LINK_BAUD;
   localparam int DATA_TIMEOUT_US = 5000;
   localparam int DATA_TIMEOUT_CYCLES = DATA_TIMEOUT_US * (CLK_HZ / 1_000_000);

   // ************************************************************
   // Link framing
   // ************************************************************
   localparam logic [3:0] FRAME_START_IDX = 4'h0;
   localparam logic [3:0] FRAME_STOP_IDX = 4'h9;

   // ************************************************************
   // Command and reply codes
   // ************************************************************
   localparam logic [7:0] CMD_SET_CFG0 = 8'h81;
   localparam logic [7:0] CMD_GET_CFG0 = 8'h82;
   localparam logic [7:0] CMD_SET_REF = 8'h83;
   localparam logic [7:0] CMD_GET_REF = 8'h84;
   localparam logic [7:0] CMD_STAT0 = 8'h85;
   localparam logic [7:0] CMD_STAT1 = 8'h86;
   localparam logic [7:0] CMD_SET_CFG2 = 8'h87;
   localparam logic [7:0] CMD_GET_CFG2 = 8'h88;
   localparam int CMD_FLAG_BIT = 7;
   localparam int ACK_FLAG_BIT = 6;
   localparam logic [7:0] ACK_STAT1 = 8'h46;

   // ************************************************************
   // Register layout and reset values
   // ************************************************************
   localparam logic [7:0] CFG0_WRITE_MASK = 8'h7f;
   localparam logic [7:0] CFG2_WRITE_MASK = 8'h1f;
   localparam logic [7:0] CFG0_RESET = 8'h00;
   localparam logic [7:0] REF_RESET = 8'h40;
   localparam logic [7:0] CFG2_RESET = 8'h00;
   localparam int CFG0_PULLUP_BIT = 6;
   localparam int CFG0_SLEEP_BIT = 5;
   localparam int CFG0_NEUTRAL_BIT = 4;
   localparam int CFG0_GATE_LOCK_BIT = 3;
   localparam int CFG0_SHORT_BIT = 2;
   localparam int CFG0_OC_LSB = 0;
   localparam int CFG2_DEAD_LSB = 2;
   localparam int CFG2_BLANK_LSB = 0;
   localparam logic [7:0] STAT1_LIVE_MASK = 8'h2c;
   localparam logic [7:0] STAT1_CFG_LOST = 8'h10;

   // ************************************************************
   // Configuration carried to the analog blocks
   // ************************************************************
   typedef struct packed {
      logic pullup_connect;
      logic sleep_sel;
      logic neutral_sim_en;
      logic gate_lockout_en;
      logic short_detect_en;
      logic [1:0] oc_thresh;
      logic [7:0] current_ref;
      logic [2:0] dead_time_sel;
      logic [1:0] blank_time_sel;
   } dcm_cfg_t;

   localparam dcm_cfg_t CFG_OUT_RESET = '{
      pullup_connect: 1'b1,
      sleep_sel: 1'b0,
      neutral_sim_en: 1'b0,
      gate_lockout_en: 1'b1,
      short_detect_en: 1'b1,
      oc_thresh: 2'h0,
      current_ref: REF_RESET,
      dead_time_sel: 3'h0,
      blank_time_sel: 2'h0
   };

endpackage : dcm_pkg

// >>> core/dcm_link_uart.sv
`timescale 1ns/100ps
// ************************************************************
// Half-duplex byte framer for the single-wire link
// ************************************************************
module dcm_link_uart #(
   parameter int BIT_CYCLES = dcm_pkg::BIT_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Line
   input wire logic i_line,
   output logic o_drive_low,
   // Received bytes
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_rx_busy,
   // Bytes to send
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready
);
   localparam int CW = $clog2(BIT_CYCLES);

   logic [CW-1:0] rx_cnt;
   logic [CW-1:0] tx_cnt;
   logic [3:0] rx_bit;
   logic [3:0] tx_bit;
   logic [7:0] rx_shift;
   logic [9:0] tx_shift;
   logic line_prev;
   logic tx_busy;

   assign o_tx_ready = !tx_busy;

   // ************************************************************
   // Receiver, blind while we transmit so our own echo is dropped
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         line_prev <= 1'b1;
         o_rx_busy <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data <= 8'h00;
         rx_shift <= 8'h00;
         rx_cnt <= '0;
         rx_bit <= 4'h0;
      end else begin
         line_prev <= i_line;
         o_rx_valid <= 1'b0;
         if (!o_rx_busy) begin
            if (line_prev && !i_line && !tx_busy) begin // [R22]
               o_rx_busy <= 1'b1;
               rx_cnt <= CW'(BIT_CYCLES / 2 - 1);
               rx_bit <= dcm_pkg::FRAME_START_IDX;
            end
         end else if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
         end else begin
            rx_cnt <= CW'(BIT_CYCLES - 1);
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == dcm_pkg::FRAME_START_IDX && i_line) begin
               o_rx_busy <= 1'b0;
            end else if (rx_bit == dcm_pkg::FRAME_STOP_IDX) begin
               // A low stop bit is a framing error: the byte is dropped
               o_rx_busy <= 1'b0;
               o_rx_valid <= i_line; // [R22]
               o_rx_data <= rx_shift;
            end else if (rx_bit != dcm_pkg::FRAME_START_IDX) begin
               rx_shift <= {i_line, rx_shift[7:1]};
            end
         end
      end
   end

   // ************************************************************
   // Transmitter, start bit, eight data bits LSB first, stop bit
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_busy <= 1'b0;
         tx_shift <= 10'h3ff;
         tx_cnt <= '0;
         tx_bit <= 4'h0;
         o_drive_low <= 1'b0;
      end else if (!tx_busy) begin
         if (i_tx_valid) begin
            tx_busy <= 1'b1;
            tx_shift <= {1'b1, i_tx_data, 1'b0}; // [R22]
            tx_cnt <= CW'(BIT_CYCLES - 1);
            tx_bit <= dcm_pkg::FRAME_START_IDX;
            o_drive_low <= 1'b1;
         end
      end else if (tx_cnt != '0) begin
         tx_cnt <= tx_cnt - 1'b1;
      end else if (tx_bit == dcm_pkg::FRAME_STOP_IDX) begin
         tx_busy <= 1'b0;
         o_drive_low <= 1'b0;
      end else begin
         tx_shift <= {1'b1, tx_shift[9:1]};
         tx_bit <= tx_bit + 4'h1;
         tx_cnt <= CW'(BIT_CYCLES - 1);
         o_drive_low <= !tx_shift[1];
      end
   end

endmodule : dcm_link_uart

// >>> tb/dcm_host_model.sv
`timescale 1ns/100ps
// ********
// Host UART on the shared wire
// ********
module dcm_host_model #(
   parameter int B = 16
) (
   // Clock
   input wire logic i_clk,
   // Shared wire, pulled up
   input wire logic i_line,
   output logic o_low
);
   logic [7:0] rxq [$];
   logic [7:0] b;
   logic [9:0] f;
   initial o_low = 1'b0;
   // Changes only at falling edges, so the device never samples a moving bit
   task automatic send(input logic [7:0] v);
      f = {1'b1, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_low <= ~f[i];
         repeat (B) @(negedge i_clk);
      end
   endtask : send
   // Own frames are ignored: a start is only seen while the host is not pulling
   always begin
      @(negedge i_clk);
      if (!i_line && !o_low) begin
         repeat (B / 2) @(negedge i_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (B) @(negedge i_clk);
            b[i] = i_line;
         end
         repeat (B) @(negedge i_clk);
         if (i_line)
            rxq.push_back(b);
      end
   end
endmodule : dcm_host_model

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   // ********
   // Wiring and checks
   // ********
   localparam int B = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic oe_n, lost, lo;
   logic [7:0] sup = 8'h00;
   logic [7:0] gate = 8'h00;
   logic [7:0] c0, rf, c2, d, e;
   logic [7:0] wr [3] = '{8'h81, 8'h83, 8'h87};
   logic [7:0] rd [3] = '{8'h82, 8'h84, 8'h88};
   dcm_pkg::dcm_cfg_t cfg;
   int err_total = 0;
   int total_checks = 0;
   wire host_low;
   // The device pulls only while enabled, and then with the level it drives
   wire link = ~(host_low | (~oe_n & ~lo));
   initial forever #12.5 clk = ~clk;
   dcm_msg_handler #(.BIT_CYCLES(B), .TIMEOUT_CYCLES(400)) dcm_msg_handler_i (.I_CLK_SYS(clk), .I_RST(rst),
      .I_LINK_IN(link), .O_LINK_OUT(lo), .O_LINK_OE_N(oe_n), .I_CHIP_EN(en), .I_SUPPLY_FLAGS(sup),
      .I_GATE_FLAGS(gate), .O_CFG(cfg), .O_CFG_LOST(lost));
   dcm_host_model #(.B(B)) dcm_host_model_i (.i_clk(clk), .i_line(link), .o_low(host_low));
   function automatic dcm_pkg::dcm_cfg_t cx(input logic [7:0] a, r, c, input logic n);
      return '{n | (a[6] & ~a[5]), a[5], a[4], ~a[3], ~a[2], a[1:0], r, c[4:2], c[1:0]};
   endfunction : cx
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask : chk8
   task automatic chkc(input dcm_pkg::dcm_cfg_t x);
      repeat (4) @(negedge clk);
      total_checks++;
      if (cfg !== x) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, cfg, x);
      end
   endtask : chkc
   task automatic rx(input logic [7:0] x);
      int n;
      n = 0;
      while (dcm_host_model_i.rxq.size() == 0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk8(dcm_host_model_i.rxq.size() > 0 ? dcm_host_model_i.rxq.pop_front() : 8'hxx, x);
   endtask : rx
   task automatic snd(input logic [7:0] v);
      // The device is deaf until its own stop bit ends, so a start bit inside it would be lost
      repeat (B) @(negedge clk);
      dcm_host_model_i.send(v);
   endtask : snd
   task test_done;
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   // Whole run is about 20000 cycles
   initial begin
      repeat (60000) @(negedge clk);
      err_total++;
      test_done();
   end
   initial begin
      d = $urandom(35);
      c0 = 8'h00;
      rf = 8'h40;
      c2 = 8'h00;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chkc(cx(c0, rf, c2, 1'b1));
      rx(8'h86);
      rx(8'h10);
      chk8({7'h00, lost}, 8'h01);
      snd(8'h86);
      rx(8'h46);
      rx(8'h10);
      chk8({7'h00, lost}, 8'h00);
      for (int j = 0; j < 5; j++) begin
         for (int k = 0; k < 3; k++) begin
            snd(rd[k]);
            rx(rd[k] ^ 8'hc0);
            rx(k == 0 ? c0 : k == 1 ? rf : c2);
         end
         if (j == 4)
            break;
         for (int k = 0; k < 3; k++) begin
            d = j == 0 ? 8'hff : j == 1 ? 8'h40 : 8'($urandom);
            e = d & (k == 0 ? 8'h7f : k == 1 ? 8'hff : 8'h1f);
            snd(wr[k]);
            snd(d);
            rx(wr[k] ^ 8'hc0);
            rx(e);
            c0 = k == 0 ? e : c0;
            rf = k == 1 ? e : rf;
            c2 = k == 2 ? e : c2;
         end
         chkc(cx(c0, rf, c2, 1'b1));
         en = 1'b0;
         chkc(cx(c0, rf, c2, 1'b0));
         en = 1'b1;
      end
      sup = 8'($urandom) | 8'h01;
      rx(8'h85);
      rx(sup);
      snd(8'h85);
      rx(8'h45);
      rx(sup);
      gate = 8'($urandom) | 8'h04;
      rx(8'h86);
      rx(gate & 8'h2c);
      sup = 8'h00;
      gate = 8'hd3;
      repeat (400) @(negedge clk);
      chk8(8'(dcm_host_model_i.rxq.size()), 8'h00);
      snd(8'h8f);
      rx(8'h0f);
      for (int k = 0; k < 3; k++) begin
         snd(wr[k]);
         repeat (380) @(negedge clk);
         chk8(8'(dcm_host_model_i.rxq.size()), 8'h00);
         rx(wr[k] & 8'h3f);
      end
      test_done();
   end
endmodule : testbench
